// >>> src/sac_params.svh
// Constants for the successive-approximation converter control block
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH

// Register byte offsets on the Avalon-MM slave
`define SAC_OFS_STATUS_CONTROL 4'h0
`define SAC_OFS_RESULT 4'h4
`define SAC_OFS_CLOCK_CONFIG 4'h8

// Status and control field positions
`define SAC_SC_FLAG_BIT 7
`define SAC_SC_IRQ_EN_BIT 6
`define SAC_SC_CONT_BIT 5
`define SAC_SC_CHAN_MSB 4
`define SAC_SC_CHAN_LSB 0

// Clock config field positions
`define SAC_CK_DIV_MSB 7
`define SAC_CK_DIV_LSB 5
`define SAC_CK_SRC_BIT 4

// Reset values and the last input channel code
`define SAC_CHAN_POWER_DOWN 5'h1f
`define SAC_CHAN_LAST_INPUT 5'h07
`define SAC_RST_DIV 3'h0
`define SAC_RST_SRC 1'h0

// Conversion sequence, counted in conversion clock periods
`define SAC_PHASE_LAST 4'hf
`define SAC_PHASE_FIRST_BIT 4'h8
`define SAC_TICKS_PER_CONV 5'h11

// Prescaler terminal counts (divide ratio minus one)
`define SAC_DIV1_LAST 4'h0
`define SAC_DIV2_LAST 4'h1
`define SAC_DIV4_LAST 4'h3
`define SAC_DIV8_LAST 4'h7
`define SAC_DIV16_LAST 4'hf

`endif

// >>> src/sac_pkg.sv
// Types shared by the converter control block
package sac_pkg;

  typedef enum logic [1:0] {
    SAC_IDLE = 2'b00,
    SAC_WAIT_CLK = 2'b01,
    SAC_CONVERT = 2'b10
  } sac_seq_e;

  // Signals towards the analog multiplexer and comparator
  typedef struct packed {
    logic power_down;
    logic [4:0] channel_select;
    logic sample;
    logic [7:0] trial;
  } sac_afe_s;

  typedef struct packed {
    logic waitrequest;
    logic [31:0] readdata;
    logic cpu_irq;
    logic dma_req;
    logic [7:0] pin_override;
    sac_afe_s afe;
    sac_seq_e seq;
    logic [3:0] phase;
    logic [7:0] acc;
    logic [7:0] pending_result;
    logic done_evt;
    logic done_sync;
    logic [7:0] result;
    logic flag_or_dma_select;
    logic conv_irq_enable;
    logic continuous_conv;
    logic [2:0] clock_divide;
    logic clock_source_select;
    logic [3:0] presc;
    logic resume_after_stop;
    logic cmp_s1;
    logic cmp_s2;
    logic xtal_s1;
    logic xtal_s2;
    logic xtal_s3;
  } sac_state_s;

endpackage : sac_pkg

// >>> src/sac_top.sv
// Control logic of the 8-bit successive-approximation converter
`timescale 1ns/1ps
`default_nettype none
`include "sac_params.svh"

// Notes on behaviour
// - Continuous mode overwrites the result each conversion, read or not.
// - Conversions run back to back while continuous bit set; stop when cleared.
// - Continuous mode: done flag set after first conversion, held until clear.
// - Interrupt enabled: request per conversion, CPU if select 0, DMA if 1.
// - Interrupt enabled: dual bit is a software CPU/DMA selector.
// - Interrupt disabled: dual bit is read-only done flag, cleared by access.
// - Pending request drops on result read or control write; reset clears enable.
// - Converter runs normally in wait mode; CPU request can wake processor.
// - Stop mode aborts conversion; conversions resume after stop exits.
// - Continuous bit: 1 repeats, 0 converts once; reset clears it.
// - 5-bit channel select; codes 0 to 7 pick inputs 0 to 7.
// - Channel code all ones powers the converter down.
// - Unused channel codes give an undefined result.
// - One 8-bit read-only result register, updated on every completion.
// - 3-bit divider: /1, /2, /4, /8, top bit set /16.
// - Source select 1 bus clock, 0 crystal; reset selects crystal.
// - Any control register write starts a new conversion unless it selects the power-down code.
// - A conversion takes 16 to 17 conversion clock periods.
// - Selected port pin forced to input, ignores writes, reads zero.
module sac_top
  import sac_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic xtal_clk_in,
  input wire logic stop_mode,
  input wire logic comparator_in,
  output sac_afe_s afe,
  output logic [7:0] pin_override,
  output logic cpu_irq,
  output logic dma_req
);

  sac_state_s s;
  sac_state_s next_s;

  // Conversion clock divider terminal count per code
  function automatic logic [3:0] div_last(input logic [2:0] code);
    logic [3:0] r;
    r = `SAC_DIV16_LAST;
    if (!code[2]) begin
      case (code[1:0])
        2'b00: r = `SAC_DIV1_LAST;
        2'b01: r = `SAC_DIV2_LAST;
        2'b10: r = `SAC_DIV4_LAST;
        default: r = `SAC_DIV8_LAST;
      endcase
    end
    return r;
  endfunction : div_last

  // Trial code for a phase: accumulated bits plus the bit under test
  function automatic logic [7:0] trial_of(input logic [7:0] acc, input logic [3:0] phase);
    logic [7:0] r;
    logic [2:0] idx;
    r = 8'h00;
    idx = 3'(`SAC_PHASE_LAST - phase);
    if (phase >= `SAC_PHASE_FIRST_BIT) begin
      r = acc;
      r[idx] = 1'b1;
    end
    return r;
  endfunction : trial_of

  function automatic logic is_power_down(input logic [4:0] ch);
    return ch == `SAC_CHAN_POWER_DOWN;
  endfunction : is_power_down

  logic accept;
  logic wr_sc;
  logic wr_ck;
  logic rd_res;
  logic src_tick;
  logic conv_tick;
  logic start_req;
  logic [2:0] bit_idx;

  assign afe = s.afe;
  assign pin_override = s.pin_override;
  assign cpu_irq = s.cpu_irq;
  assign dma_req = s.dma_req;
  assign avs_readdata = s.readdata;
  assign avs_waitrequest = s.waitrequest;

  always_comb begin
    next_s = s;

    // Two-stage synchronisers; first stage feeds only the second
    next_s.cmp_s1 = comparator_in;
    next_s.cmp_s2 = s.cmp_s1;
    next_s.xtal_s1 = xtal_clk_in;
    next_s.xtal_s2 = s.xtal_s1;
    next_s.xtal_s3 = s.xtal_s2;

    // Bus slave: one wait state, the access completes on the edge waitrequest is low
    accept = (avs_read || avs_write) && !s.waitrequest;
    wr_sc = accept && avs_write && avs_byteenable[0] && avs_address == `SAC_OFS_STATUS_CONTROL;
    wr_ck = accept && avs_write && avs_byteenable[0] && avs_address == `SAC_OFS_CLOCK_CONFIG;
    rd_res = accept && avs_read && avs_address == `SAC_OFS_RESULT;
    next_s.waitrequest = !((avs_read || avs_write) && s.waitrequest);
    next_s.readdata = 32'h0000_0000;
    if ((avs_read || avs_write) && s.waitrequest && avs_read) begin
      case (avs_address)
        `SAC_OFS_STATUS_CONTROL: begin
          next_s.readdata[`SAC_SC_FLAG_BIT] = s.flag_or_dma_select;
          next_s.readdata[`SAC_SC_IRQ_EN_BIT] = s.conv_irq_enable;
          next_s.readdata[`SAC_SC_CONT_BIT] = s.continuous_conv;
          next_s.readdata[`SAC_SC_CHAN_MSB:`SAC_SC_CHAN_LSB] = s.afe.channel_select;
        end
        `SAC_OFS_RESULT: next_s.readdata[7:0] = s.result;
        `SAC_OFS_CLOCK_CONFIG: begin
          next_s.readdata[`SAC_CK_DIV_MSB:`SAC_CK_DIV_LSB] = s.clock_divide;
          next_s.readdata[`SAC_CK_SRC_BIT] = s.clock_source_select;
        end
        default: next_s.readdata = 32'h0000_0000;
      endcase
    end

    // Clock configuration; changing it mid-conversion corrupts that result
    if (wr_ck) begin
      next_s.clock_divide = avs_writedata[`SAC_CK_DIV_MSB:`SAC_CK_DIV_LSB];
      next_s.clock_source_select = avs_writedata[`SAC_CK_SRC_BIT];
    end

    // Conversion clock: bus clock every cycle or crystal rising edge, then divided
    src_tick = s.clock_source_select ? 1'b1 : (s.xtal_s2 && !s.xtal_s3);
    conv_tick = 1'b0;
    if (stop_mode) begin
      next_s.presc = 4'h0;
    end else if (src_tick) begin
      if (s.presc >= div_last(s.clock_divide)) begin
        next_s.presc = 4'h0;
        conv_tick = 1'b1;
      end else begin
        next_s.presc = s.presc + 4'h1;
      end
    end

    // Sequencer
    next_s.done_evt = 1'b0;
    bit_idx = 3'(`SAC_PHASE_LAST - s.phase);
    case (s.seq)
      SAC_IDLE: begin
      end
      SAC_WAIT_CLK: begin
        if (conv_tick) begin
          next_s.seq = SAC_CONVERT;
          next_s.phase = 4'h0;
          next_s.acc = 8'h00;
        end
      end
      SAC_CONVERT: begin
        if (conv_tick) begin
          if (s.phase >= `SAC_PHASE_FIRST_BIT) begin
            next_s.acc[bit_idx] = s.cmp_s2;
          end
          if (s.phase == `SAC_PHASE_LAST) begin
            next_s.seq = SAC_IDLE;
            next_s.done_evt = 1'b1;
            next_s.pending_result = next_s.acc;
          end else begin
            next_s.phase = s.phase + 4'h1;
          end
        end
      end
      default: next_s.seq = SAC_IDLE;
    endcase

    // Retimed completion drives all software-visible updates
    next_s.done_sync = s.done_evt;

    // Clears from software access; completion below wins over them
    if (rd_res || wr_sc) begin
      next_s.cpu_irq = 1'b0;
      next_s.dma_req = 1'b0;
      if (!s.conv_irq_enable) begin
        next_s.flag_or_dma_select = 1'b0;
      end
    end
    if (wr_sc) begin
      next_s.conv_irq_enable = avs_writedata[`SAC_SC_IRQ_EN_BIT];
      next_s.continuous_conv = avs_writedata[`SAC_SC_CONT_BIT];
      next_s.afe.channel_select = avs_writedata[`SAC_SC_CHAN_MSB:`SAC_SC_CHAN_LSB];
      // Selector is writable only with interrupts enabled; else the write clears the flag
      next_s.flag_or_dma_select = avs_writedata[`SAC_SC_IRQ_EN_BIT] &&
                                  avs_writedata[`SAC_SC_FLAG_BIT];
    end

    start_req = 1'b0;
    if (s.done_sync) begin
      next_s.result = s.pending_result;
      if (s.conv_irq_enable) begin
        if (s.flag_or_dma_select) begin
          next_s.dma_req = 1'b1;
        end else begin
          next_s.cpu_irq = 1'b1;
        end
      end else begin
        next_s.flag_or_dma_select = 1'b1;
      end
      start_req = s.continuous_conv;
    end
    if (wr_sc) begin
      // A write also aborts any running conversion and restarts it unless the power-down code is written
      start_req = 1'b1;
    end
    if (start_req && !is_power_down(next_s.afe.channel_select)) begin
      next_s.seq = SAC_WAIT_CLK;
      next_s.phase = 4'h0;
      next_s.acc = 8'h00;
      next_s.done_evt = 1'b0;
    end

    // Stop: abandon conversion, remember to restart once stop ends
    if (stop_mode) begin
      if (next_s.seq != SAC_IDLE || s.resume_after_stop) begin
        next_s.resume_after_stop = 1'b1;
      end
      next_s.seq = SAC_IDLE;
      next_s.done_evt = 1'b0;
    end else if (s.resume_after_stop) begin
      next_s.resume_after_stop = 1'b0;
      if (!is_power_down(next_s.afe.channel_select)) begin
        next_s.seq = SAC_WAIT_CLK;
        next_s.phase = 4'h0;
        next_s.acc = 8'h00;
      end
    end

    // Powering down idles the sequencer and front end
    if (is_power_down(next_s.afe.channel_select)) begin
      next_s.seq = SAC_IDLE;
      next_s.resume_after_stop = 1'b0;
    end
    next_s.afe.power_down = is_power_down(next_s.afe.channel_select) || stop_mode;
    next_s.afe.sample = next_s.seq == SAC_CONVERT && next_s.phase < `SAC_PHASE_FIRST_BIT;
    next_s.afe.trial = next_s.seq == SAC_CONVERT ? trial_of(next_s.acc, next_s.phase) : 8'h00;

    // Unused codes still convert; result is whatever the comparator gives
    next_s.pin_override = 8'h00;
    if (next_s.afe.channel_select <= `SAC_CHAN_LAST_INPUT) begin
      next_s.pin_override[next_s.afe.channel_select[2:0]] = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s <= '0;
      s.waitrequest <= 1'b1;
      s.seq <= SAC_IDLE;
      s.conv_irq_enable <= 1'b0;
      s.continuous_conv <= 1'b0;
      s.clock_source_select <= `SAC_RST_SRC;
      s.clock_divide <= `SAC_RST_DIV;
      s.afe.channel_select <= `SAC_CHAN_POWER_DOWN;
      s.afe.power_down <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Helper: conversion clock ticks since the conversion was started
  logic [4:0] tick_count;
  always_ff @(posedge ref_clk) begin
    if (rst || s.seq == SAC_IDLE) begin
      tick_count <= 5'h00;
    end else if (next_s.seq == SAC_WAIT_CLK && (s.seq != SAC_WAIT_CLK || conv_tick)) begin
      tick_count <= 5'h00;
    end else if (conv_tick) begin
      tick_count <= tick_count + 5'h01;
    end
  end

  property p_conv_len;
    @(posedge ref_clk) disable iff (rst)
    s.done_evt |-> tick_count == `SAC_TICKS_PER_CONV;
  endproperty
  a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

  property p_result_update;
    @(posedge ref_clk) disable iff (rst)
    s.done_evt |=> ##1 (s.result == $past(s.pending_result));
  endproperty
  a_result_update: assert property (p_result_update) else $error("result not updated");

  property p_cont_restart;
    @(posedge ref_clk) disable iff (rst)
    (s.done_sync && s.continuous_conv && !stop_mode && !is_power_down(s.afe.channel_select))
      |=> s.seq == SAC_WAIT_CLK;
  endproperty
  a_cont_restart: assert property (p_cont_restart) else $error("continuous restart missing");

  property p_single_stop;
    @(posedge ref_clk) disable iff (rst)
    (s.done_sync && !s.continuous_conv && !wr_sc && !s.resume_after_stop) |=> s.seq == SAC_IDLE;
  endproperty
  a_single_stop: assert property (p_single_stop) else $error("single conversion repeated");

  property p_flag_set;
    @(posedge ref_clk) disable iff (rst)
    (s.done_sync && !s.conv_irq_enable) |=> s.flag_or_dma_select;
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("done flag not set");

  property p_cpu_irq;
    @(posedge ref_clk) disable iff (rst)
    (s.done_sync && s.conv_irq_enable && !s.flag_or_dma_select) |=> cpu_irq && !(dma_req && !$past(dma_req));
  endproperty
  a_cpu_irq: assert property (p_cpu_irq) else $error("cpu request missing");

  property p_dma_req;
    @(posedge ref_clk) disable iff (rst)
    (s.done_sync && s.conv_irq_enable && s.flag_or_dma_select) |=> dma_req;
  endproperty
  a_dma_req: assert property (p_dma_req) else $error("dma request missing");

  property p_clear_on_read;
    @(posedge ref_clk) disable iff (rst)
    (rd_res && !s.done_sync) |=> !cpu_irq && !dma_req;
  endproperty
  a_clear_on_read: assert property (p_clear_on_read) else $error("request not cleared");

  property p_stop_abort;
    @(posedge ref_clk) disable iff (rst)
    stop_mode |=> s.seq == SAC_IDLE && afe.power_down;
  endproperty
  a_stop_abort: assert property (p_stop_abort) else $error("stop did not abort");

  property p_write_start;
    @(posedge ref_clk) disable iff (rst)
    (wr_sc && !stop_mode && avs_writedata[`SAC_SC_CHAN_MSB:`SAC_SC_CHAN_LSB] != `SAC_CHAN_POWER_DOWN)
      |=> s.seq == SAC_WAIT_CLK;
  endproperty
  a_write_start: assert property (p_write_start) else $error("write did not start");

  property p_power_down;
    @(posedge ref_clk) disable iff (rst)
    (afe.channel_select == `SAC_CHAN_POWER_DOWN) |-> afe.power_down && s.seq == SAC_IDLE;
  endproperty
  a_power_down: assert property (p_power_down) else $error("power down ignored");

endmodule : sac_top
`default_nettype wire

// >>> verif/sac_afe_model.sv
// Behavioural analog multiplexer and comparator facing the converter control
`timescale 1ns/1ps
`default_nettype none
module sac_afe_model
  import sac_pkg::*;
(
  input wire logic ref_clk,
  input wire sac_afe_s afe,
  input wire logic [63:0] levels,
  input wire logic slow,
  output logic comparator_in
);
  logic [7:0] vin;
  logic fast;
  logic late = 1'b0;
  logic noise = 1'b0;
  assign vin = levels[afe.channel_select[2:0]*8+:8];
  assign fast = (vin >= afe.trial);
  always_ff @(posedge ref_clk) begin
    late <= fast;
    noise <= ~noise;
  end
  // Unselected or powered-down input gives a changing level, never a held one
  assign comparator_in = (afe.power_down || afe.channel_select > 5'h07) ? noise :
    (slow ? late : fast);
endmodule : sac_afe_model
`default_nettype wire

// >>> verif/tb_sac_top.sv
// Self-checking testbench for the converter control block
`timescale 1ns/1ps
`default_nettype none
`include "sac_params.svh"
module tb_sac_top
  import sac_pkg::*;
;
  localparam logic [3:0] a_sc = `SAC_OFS_STATUS_CONTROL;
  localparam logic [3:0] a_res = `SAC_OFS_RESULT;
  localparam logic [3:0] a_ck = `SAC_OFS_CLOCK_CONFIG;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic xtal_clk_in = 1'b0;
  logic stop_mode = 1'b0;
  logic comparator_in;
  sac_afe_s afe;
  logic [7:0] pin_override;
  logic cpu_irq;
  logic dma_req;
  logic [63:0] levels = 64'h19e04b8000ffa53c;
  logic slow = 1'b0;
  logic [31:0] rd;
  int n_fail = 0;
  int num_checks = 0;
  int cyc = 0;
  int lat;
  int d;

  sac_top u_dut (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .xtal_clk_in(xtal_clk_in),
    .stop_mode(stop_mode), .comparator_in(comparator_in), .afe(afe), .pin_override(pin_override),
    .cpu_irq(cpu_irq), .dma_req(dma_req));
  sac_afe_model u_afe (.ref_clk(ref_clk), .afe(afe), .levels(levels), .slow(slow),
    .comparator_in(comparator_in));

  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  // Crystal runs at an eighth of the bus clock so the retiming keeps up
  always @(posedge ref_clk) begin
    cyc <= cyc + 1;
    if (cyc % 4 == 3) xtal_clk_in <= ~xtal_clk_in;
    if (cyc == 20000) begin
      n_fail++;
      report_and_stop();
    end
  end

  task report_and_stop;
    $display("checks=%0d fails=%0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : report_and_stop

  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task bus(input logic wr, input logic [3:0] a, input logic [7:0] dat);
    @(posedge ref_clk);
    avs_address <= a;
    avs_writedata <= {24'h0, dat};
    avs_write <= wr;
    avs_read <= ~wr;
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task wait_flag;
    repeat (300) begin
      bus(1'b0, a_sc, 8'h00);
      if (rd[7] === 1'b1) break;
    end
  endtask : wait_flag

  task wait_req(input logic dma);
    lat = 0;
    do begin
      @(posedge ref_clk);
      lat++;
    end while ((dma ? dma_req : cpu_irq) !== 1'b1 && lat < 2000);
    chk(lat < 2000, 1'b1);
  endtask : wait_req

  task settle;
    repeat (2) @(negedge ref_clk);
  endtask : settle

  task t_reset;
    chk(afe.power_down, 1'b1);
    chk({afe.sample, afe.trial}, 9'h000);
    bus(1'b0, a_sc, 8'h00);
    chk(rd, 32'h1f);
    bus(1'b0, a_ck, 8'h00);
    chk(rd, 32'h00);
    bus(1'b0, 4'hc, 8'h00);
    chk(rd, 32'h00);
    avs_byteenable <= 4'he;
    bus(1'b1, a_ck, 8'h70);
    avs_byteenable <= 4'hf;
    bus(1'b0, a_ck, 8'h00);
    chk(rd, 32'h00);
  endtask : t_reset

  task t_single;
    bus(1'b1, a_ck, 8'h70);
    bus(1'b1, a_sc, 8'h06);
    wait_flag();
    chk(rd, 32'h86);
    chk(pin_override, 8'h40);
    bus(1'b1, a_res, 8'h5a);
    bus(1'b0, a_res, 8'h00);
    chk(rd, 32'he0);
    bus(1'b0, a_sc, 8'h00);
    chk(rd, 32'h06);
    repeat (300) @(posedge ref_clk);
    bus(1'b0, a_sc, 8'h00);
    chk(rd, 32'h06);
  endtask : t_single

  task t_irq;
    bus(1'b1, a_sc, 8'h45);
    wait_req(1'b0);
    chk(dma_req, 1'b0);
    bus(1'b0, a_sc, 8'h00);
    chk(rd, 32'h45);
    bus(1'b0, a_res, 8'h00);
    chk(rd, 32'h4b);
    settle();
    chk(cpu_irq, 1'b0);
    bus(1'b1, a_sc, 8'hc1);
    wait_req(1'b1);
    chk({dma_req, cpu_irq}, 2'b10);
    bus(1'b0, a_sc, 8'h00);
    chk(rd, 32'hc1);
    bus(1'b1, a_sc, 8'h1f);
    settle();
    chk({dma_req, afe.power_down}, 2'b01);
  endtask : t_irq

  task t_cont;
    bus(1'b1, a_sc, 8'h22);
    wait_flag();
    levels[23:16] <= 8'h2d;
    repeat (400) @(posedge ref_clk);
    bus(1'b0, a_sc, 8'h00);
    chk(rd, 32'ha2);
    bus(1'b0, a_res, 8'h00);
    chk(rd, 32'h2d);
    wait_flag();
    chk(rd, 32'ha2);
    bus(1'b1, a_sc, 8'h02);
    repeat (300) @(posedge ref_clk);
    bus(1'b0, a_res, 8'h00);
    repeat (300) @(posedge ref_clk);
    bus(1'b0, a_sc, 8'h00);
    chk(rd, 32'h02);
  endtask : t_cont

  task t_stop;
    slow <= 1'b1;
    bus(1'b1, a_ck, 8'h00);
    bus(1'b1, a_sc, 8'h00);
    repeat (40) @(posedge ref_clk);
    stop_mode <= 1'b1;
    repeat (400) @(posedge ref_clk);
    bus(1'b0, a_sc, 8'h00);
    chk(rd, 32'h00);
    stop_mode <= 1'b0;
    wait_flag();
    chk(rd[7], 1'b1);
    bus(1'b0, a_res, 8'h00);
    bus(1'b1, a_sc, 8'h00);
    wait_flag();
    chk(rd[7], 1'b1);
    bus(1'b0, a_res, 8'h00);
    chk(rd, 32'h3c);
    slow <= 1'b0;
  endtask : t_stop

  task t_div;
    for (int c = 0; c < 8; c++) begin
      d = (c >= 4) ? 16 : (1 << c);
      bus(1'b1, a_ck, {c[2:0], 5'h10});
      bus(1'b1, a_sc, 8'h40);
      wait_req(1'b0);
      chk(lat >= 16 * d && lat <= 17 * d + 8, 1'b1);
      bus(1'b0, a_res, 8'h00);
    end
    // Unused channel still converts, but no pin is taken over
    bus(1'b1, a_sc, 8'h08);
    wait_flag();
    chk(rd[7], 1'b1);
    chk(pin_override, 8'h00);
    bus(1'b1, a_sc, 8'h1f);
  endtask : t_div

  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    t_reset();
    t_single();
    t_irq();
    t_cont();
    t_stop();
    t_div();
    report_and_stop();
  end
endmodule : tb_sac_top
`default_nettype wire
